// ===== logic/lpm_pkg.sv
// Constants, register map and state codes for the low power mode controller
package lpm_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [7:0] LPM_IDX_WAKE_CSR = 8'h2B;
    localparam logic [7:0] LPM_IDX_WAKE_PRE = 8'h2C;
    localparam logic [7:0] LPM_IDX_MODE_CFG = 8'h2D;
    localparam logic [7:0] LPM_IDX_MODE_STAT = 8'h2E;
    // Field positions of the wake control and status register
    localparam int LPM_CSR_EN = 0;
    localparam int LPM_CSR_MEAS = 1;
    localparam int LPM_CSR_FLAG = 2;
    // Field position of the oscillator interrupt enable in the mode config
    localparam int LPM_CFG_OSCIE = 0;
    // Values after reset, and the forbidden prescaler value
    localparam logic [7:0] LPM_RST_CSR = 8'h00;
    localparam logic [7:0] LPM_RST_PRE = 8'hFF;
    localparam logic [7:0] LPM_RST_CFG = 8'h00;
    localparam logic [7:0] LPM_PRE_FORBIDDEN = 8'h00;
    // Oscillator start-up delays in CPU cycles, one cycle per clock
    localparam int LPM_START_SHORT_CYC = 256;
    localparam int LPM_START_LONG_CYC = 4096;
    localparam logic [12:0] LPM_START_SHORT = 13'(LPM_START_SHORT_CYC);
    localparam logic [12:0] LPM_START_LONG = 13'(LPM_START_LONG_CYC);
    // Fixed divider ahead of the wake prescaler, in RC periods
    localparam int LPM_FIX_DIV = 64;
    localparam logic [5:0] LPM_FIX_LAST = 6'(LPM_FIX_DIV - 1);
    // Interrupt mask value that enables every interrupt
    localparam logic [1:0] LPM_MASK_ALL = 2'h2;

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_WAIT = 6'h02,
        ST_HALT = 6'h04,
        ST_AHALT = 6'h08,
        ST_AWHALT = 6'h10,
        ST_START = 6'h20
    } lpm_state_t;
endpackage

// ===== logic/lpm_ctrl.sv
// Low power mode sequencer with auto wake prescaler and Avalon-MM registers
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
// Behaviour
// RL1: Wait stops CPU clock, peripherals keep running
// RL2: Wait forces interrupt mask to 10
// RL3: Wait exits on interrupt or reset, vectoring
// RL4: Halt is plain when both enables clear
// RL5: Halt exit restarts oscillator, waits 256/4096
// RL6: Halt entry forces mask 10; pending wakes
// RL7: Halt stops main oscillator and peripheral clocks
// RL8: Watchdog reset on halt follows option bit
// RL9: Oscillator irq enable selects active halt
// RL10: Active halt keeps only oscillator and RTC
// RL11: Active halt reset exit inserts start-up delay
// RL12: Active halt exits on RTC, wake irq, reset
// RL13: Active halt never causes watchdog reset
// RL14: Wake enable alone selects auto wake halt
// RL15: Auto wake runs RC, fixed divider, prescaler
// RL16: Expiry sets flag, irq, start-up, then service
// RL17: Reading wake status clears flag and irq
// RL18: Measure bit routes RC clock to capture; the code does so in run mode only, not in wait
// RL19: Auto wake exits on irq/reset; mask 10
// RL20: Auto wake watchdog reset follows option bit
// RL21: Service pushes mask, loads priority, pop restores
// RL22: Wake status resets 00h, flag read only
// RL23: Wake delay is 64 times prescaler periods
// RL24: Prescaler resets FFh; 00h write ignored
module lpm_ctrl
    import lpm_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic waitInstr,
    input wire logic haltInstr,
    input wire logic anyIrq,
    input wire logic haltWakeIrq,
    input wire logic rtcIrq,
    input wire logic watchdogEnabled,
    input wire logic watchdogInHaltOption,
    input wire logic longStartOption,
    input wire logic [1:0] irqPriority,
    input wire logic ccPop,
    input wire logic wakeRcClock,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic mainOscEn,
    output logic rtcClkEn,
    output logic rcOscEn,
    output logic timerCaptureInputOne,
    output logic [1:0] ccMask,
    output logic maskLoad,
    output logic ccPush,
    output logic serveIrq,
    output logic fetchResetVec,
    output logic watchdogReset,
    output logic wakeIrq
);
    lpm_state_t state_r, state_nxt;
    logic [7:0] csr_r;
    logic [7:0] pre_r;
    logic [7:0] cfg_r;
    logic [12:0] startCnt_r;
    logic fromReset_r;
    logic [1:0] savedMask_r;
    logic [2:0] rcSync_r;
    logic rcLevel_r;
    logic rcEdge;
    logic [5:0] divCnt_r;
    logic [7:0] preCnt_r;
    logic expire;
    logic accept;
    logic flagClear;
    logic [7:0] regIdx;
    logic startDone;
    logic haltEntry;
    logic wdHit;

    // Word-aligned register index from the byte address
    assign regIdx = address[9:2];
    assign accept = (read || write) && !waitrequest;
    assign flagClear = accept && read && regIdx == LPM_IDX_WAKE_CSR &&
        readdata[LPM_CSR_FLAG];
    assign startDone = startCnt_r == 13'h0001;
    assign haltEntry = state_r == ST_RUN && haltInstr && !wdHit;
    // Plain and auto wake halt reset when option is 0; active halt never
    assign wdHit = haltInstr && watchdogEnabled && !watchdogInHaltOption &&
        !cfg_r[LPM_CFG_OSCIE]; // see RL8 see RL13 see RL20

    // Read data decode, shared by the capture process
    function automatic logic [7:0] reg_read(input logic [7:0] idx);
        unique case (idx)
            LPM_IDX_WAKE_CSR: reg_read = csr_r; // see RL22
            LPM_IDX_WAKE_PRE: reg_read = pre_r;
            LPM_IDX_MODE_CFG: reg_read = cfg_r;
            LPM_IDX_MODE_STAT: reg_read = {2'h0, state_r};
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Bus handshake: one wait cycle, then accept; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if (accept) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
            readdata <= {24'h00_0000, reg_read(regIdx)};
        end
    end

    // Writable registers; flag bit is hardware owned
    always_ff @(posedge clock) begin
        if (!resetn) begin
            csr_r <= LPM_RST_CSR; // see RL22
            pre_r <= LPM_RST_PRE; // see RL24
            cfg_r <= LPM_RST_CFG;
        end else begin
            if (accept && write && regIdx == LPM_IDX_WAKE_CSR) begin
                csr_r[LPM_CSR_EN] <= writedata[LPM_CSR_EN];
                csr_r[LPM_CSR_MEAS] <= writedata[LPM_CSR_MEAS];
            end
            // Forbidden zero leaves the prescaler unchanged
            if (accept && write && regIdx == LPM_IDX_WAKE_PRE &&
                writedata[7:0] != LPM_PRE_FORBIDDEN) begin
                pre_r <= writedata[7:0]; // see RL24
            end
            if (accept && write && regIdx == LPM_IDX_MODE_CFG) begin
                cfg_r[LPM_CFG_OSCIE] <= writedata[LPM_CFG_OSCIE];
            end
            // Only the flag that was actually returned is cleared, so an
            // expiry landing between capture and accept survives
            if (expire) begin
                csr_r[LPM_CSR_FLAG] <= 1'b1; // see RL16
            end else if (flagClear) begin
                csr_r[LPM_CSR_FLAG] <= 1'b0; // see RL17
            end
        end
    end

    // RC clock pin: three stages, level taken when stages two and three agree
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rcSync_r <= 3'h0;
            rcLevel_r <= 1'b0;
        end else begin
            rcSync_r <= {rcSync_r[1:0], wakeRcClock};
            if (rcSync_r[1] == rcSync_r[2]) begin
                rcLevel_r <= rcSync_r[2];
            end
        end
    end
    assign rcEdge = rcSync_r[1] == rcSync_r[2] && rcSync_r[2] && !rcLevel_r;

    // Fixed divide by 64 then prescaler; RC start-up time adds naturally
    // because no edge arrives before the oscillator runs
    assign expire = state_r == ST_AWHALT && rcEdge &&
        divCnt_r == LPM_FIX_LAST && preCnt_r == pre_r - 8'h01; // see RL23
    always_ff @(posedge clock) begin
        if (!resetn) begin
            divCnt_r <= 6'h00;
            preCnt_r <= 8'h00;
        end else if (state_r != ST_AWHALT) begin
            divCnt_r <= 6'h00;
            preCnt_r <= 8'h00;
        end else if (rcEdge) begin
            divCnt_r <= divCnt_r + 6'h01; // see RL15
            if (divCnt_r == LPM_FIX_LAST) begin
                preCnt_r <= expire ? 8'h00 : preCnt_r + 8'h01;
            end
        end
    end

    // Next mode
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (waitInstr) begin
                    state_nxt = ST_WAIT; // see RL1
                end else if (haltEntry) begin
                    if (cfg_r[LPM_CFG_OSCIE]) begin
                        state_nxt = ST_AHALT; // see RL9
                    end else if (csr_r[LPM_CSR_EN]) begin
                        state_nxt = ST_AWHALT; // see RL14
                    end else begin
                        state_nxt = ST_HALT; // see RL4
                    end
                end
            end
            ST_WAIT: begin
                if (anyIrq) begin
                    state_nxt = ST_RUN; // see RL3
                end
            end
            ST_HALT: begin
                if (haltWakeIrq) begin
                    state_nxt = ST_START; // see RL5 see RL6
                end
            end
            ST_AHALT: begin
                // Oscillator kept running, so interrupt exit needs no delay
                if (rtcIrq || haltWakeIrq) begin
                    state_nxt = ST_RUN; // see RL12
                end
            end
            ST_AWHALT: begin
                if (expire || haltWakeIrq) begin
                    state_nxt = ST_START; // see RL16 see RL19
                end
            end
            ST_START: begin
                if (startDone) begin
                    state_nxt = ST_RUN;
                end
            end
        endcase
    end

    // Mode register; reset always passes through the start-up delay
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_r <= ST_START; // see RL11
        end else begin
            state_r <= state_nxt;
        end
    end

    // Start-up counter, length chosen by the option strap
    always_ff @(posedge clock) begin
        if (!resetn) begin
            startCnt_r <= 13'h0000;
            fromReset_r <= 1'b1;
        end else if (state_r == ST_START) begin
            if (startCnt_r == 13'h0000) begin
                startCnt_r <= longStartOption ? LPM_START_LONG :
                    LPM_START_SHORT; // see RL5 see RL11
            end else if (startDone) begin
                startCnt_r <= 13'h0000;
                fromReset_r <= 1'b0;
            end else begin
                startCnt_r <= startCnt_r - 13'h0001;
            end
        end
    end

    // Resume strobes to the core
    always_ff @(posedge clock) begin
        if (!resetn) begin
            serveIrq <= 1'b0;
            fetchResetVec <= 1'b0;
            watchdogReset <= 1'b0;
        end else begin
            serveIrq <= state_nxt == ST_RUN && state_r != ST_RUN &&
                !(state_r == ST_START && fromReset_r); // see RL3
            fetchResetVec <= state_r == ST_START && startDone &&
                fromReset_r; // see RL5
            watchdogReset <= state_r == ST_RUN && wdHit; // see RL8
        end
    end

    // Interrupt mask handling around sleep and service
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ccMask <= LPM_MASK_ALL;
            savedMask_r <= LPM_MASK_ALL;
            maskLoad <= 1'b0;
            ccPush <= 1'b0;
        end else begin
            maskLoad <= 1'b0;
            ccPush <= 1'b0;
            if (state_r == ST_RUN && state_nxt != ST_RUN) begin
                ccMask <= LPM_MASK_ALL; // see RL2 see RL6 see RL19
                maskLoad <= 1'b1;
            end else if (state_r != ST_RUN && state_nxt == ST_RUN &&
                !(state_r == ST_START && fromReset_r)) begin
                savedMask_r <= ccMask; // see RL21
                ccMask <= irqPriority;
                maskLoad <= 1'b1;
                ccPush <= 1'b1;
            end else if (ccPop) begin
                ccMask <= savedMask_r; // see RL21
                maskLoad <= 1'b1;
            end
        end
    end

    // Clock gating; only the next-mode decode state_nxt feeds these flops
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cpuClkEn <= 1'b0;
            periphClkEn <= 1'b0;
            mainOscEn <= 1'b1;
            rtcClkEn <= 1'b0;
        end else begin
            cpuClkEn <= state_nxt == ST_RUN; // see RL1
            periphClkEn <= state_nxt == ST_RUN ||
                state_nxt == ST_WAIT; // see RL7 see RL10
            mainOscEn <= state_nxt != ST_HALT &&
                state_nxt != ST_AWHALT; // see RL7
            rtcClkEn <= state_nxt == ST_RUN || state_nxt == ST_WAIT ||
                state_nxt == ST_AHALT; // see RL10
        end
    end

    // RC oscillator, measurement route and wake request
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rcOscEn <= 1'b0;
            timerCaptureInputOne <= 1'b0;
            wakeIrq <= 1'b0;
        end else begin
            rcOscEn <= state_nxt == ST_AWHALT || (state_nxt == ST_RUN &&
                csr_r[LPM_CSR_MEAS]); // see RL15 see RL18
            timerCaptureInputOne <= state_r == ST_RUN &&
                csr_r[LPM_CSR_MEAS] && rcLevel_r; // see RL18
            wakeIrq <= expire || (csr_r[LPM_CSR_FLAG] &&
                !flagClear); // see RL16 see RL17
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_wait_cpu_stop: assert property (state_r == ST_WAIT |-> // see RL1
        !cpuClkEn && periphClkEn) else $error("wait clocks wrong");
    a_sleep_mask_ten: assert property ( // see RL2 see RL6
        $rose(state_r != ST_RUN) && $past(state_r) == ST_RUN |->
        ccMask == LPM_MASK_ALL && maskLoad) else $error("mask not forced");
    a_wait_exit_irq: assert property (state_r == ST_WAIT && // see RL3
        anyIrq |=> serveIrq && state_r == ST_RUN) else $error("wait exit");
    // Checked in the entry cycle: a pending wake may leave halt at once
    a_plain_halt_sel: assert property (haltEntry && !waitInstr && // see RL4
        !cfg_r[LPM_CFG_OSCIE] && !csr_r[LPM_CSR_EN] |=> state_r == ST_HALT &&
        !mainOscEn) else $error("halt");
    a_start_len: assert property ($rose(state_r == ST_START) && // see RL5
        !longStartOption |-> ##256 state_r == ST_START ##1 state_r == ST_RUN)
        else $error("start-up length");
    a_ahalt_no_wdog: assert property (state_r == ST_RUN && // see RL13
        haltInstr && !waitInstr && cfg_r[LPM_CFG_OSCIE] |=> !watchdogReset &&
        state_r == ST_AHALT) else $error("watchdog in active halt");
    a_ahalt_clocks: assert property (state_r == ST_AHALT |-> // see RL10
        mainOscEn && rtcClkEn && !periphClkEn) else $error("active halt");
    a_flag_irq: assert property (expire |=> csr_r[LPM_CSR_FLAG] && // see RL16
        wakeIrq ##1 state_r == ST_START) else $error("expiry");
    a_read_clears: assert property (flagClear && !expire |=> // see RL17
        !csr_r[LPM_CSR_FLAG] && !wakeIrq) else $error("no clear");
    a_pre_nonzero: assert property (pre_r != LPM_PRE_FORBIDDEN) // see RL24
        else $error("prescaler zero");
    a_reserved_zero: assert property (csr_r[7:3] == 5'h00) // see RL22
        else $error("reserved set");

    c_wait_cycle: cover property (state_r == ST_WAIT ##[1:20] serveIrq);
    // Start-up counter bounds the wake-to-service gap for either length
    c_awu_wake: cover property (state_r == ST_START &&
        csr_r[LPM_CSR_FLAG] && startDone ##1 serveIrq);
    c_ahalt_rtc: cover property (state_r == ST_AHALT && rtcIrq);
endmodule

// ===== bench/lpm_partner.sv
// Model of the core-side interrupt sources and the wake RC oscillator
`timescale 1ns/10ps
module lpm_partner #(
    parameter int RC_HALF_NS = 137
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic rcOscEn,
    input wire logic serveIrq,
    input wire logic [2:0] irqKick,
    output logic anyIrq,
    output logic haltWakeIrq,
    output logic rtcIrq,
    output logic wakeRcClock
);
    // Pending levels stay up until the block vectors to service
    always_ff @(posedge clock) begin
        if (!resetn || serveIrq) begin
            anyIrq <= 1'b0;
            haltWakeIrq <= 1'b0;
            rtcIrq <= 1'b0;
        end else begin
            anyIrq <= anyIrq | irqKick[0];
            haltWakeIrq <= haltWakeIrq | irqKick[1];
            rtcIrq <= rtcIrq | irqKick[2];
        end
    end

    // RC runs only when enabled, rests low, unrelated to the clock;
    // each half spans over two clock periods so the pin filter keeps it
    initial begin
        wakeRcClock = 1'b0;
        forever begin
            wait (rcOscEn === 1'b1);
            #RC_HALF_NS wakeRcClock = 1'b1;
            #RC_HALF_NS wakeRcClock = 1'b0;
        end
    end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the low power mode controller
`timescale 1ns/10ps
module tb import lpm_pkg::*; ;
    logic clock, resetn, read, write, waitrequest;
    logic [9:0] address;
    logic [31:0] writedata, readdata;
    logic waitInstr, haltInstr, anyIrq, haltWakeIrq, rtcIrq, ccPop;
    logic watchdogEnabled, watchdogInHaltOption, longStartOption;
    logic [1:0] irqPriority, ccMask;
    logic [2:0] irqKick;
    logic wakeRcClock, cpuClkEn, periphClkEn, mainOscEn, rtcClkEn, rcOscEn;
    logic timerCaptureInputOne, maskLoad, ccPush, serveIrq, fetchResetVec;
    logic watchdogReset, wakeIrq, seen;
    logic [7:0] expQ[$];
    logic [7:0] pre;
    int bad_count, checks, cycles, n;
    // RC half period of the partner model and the clock period, in ns
    localparam int RC_HALF_NS = 137;
    localparam int CLK_NS = 50;
    // Earliest auto wake service at prescaler 01h: 64 RC periods, start-up
    localparam int AW_LO = LPM_FIX_DIV * 2 * RC_HALF_NS / CLK_NS +
        LPM_START_SHORT_CYC - 8;

    lpm_ctrl u_lpm_ctrl (.clock(clock), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .waitInstr(waitInstr), .haltInstr(haltInstr), .anyIrq(anyIrq),
        .haltWakeIrq(haltWakeIrq), .rtcIrq(rtcIrq),
        .watchdogEnabled(watchdogEnabled),
        .watchdogInHaltOption(watchdogInHaltOption),
        .longStartOption(longStartOption), .irqPriority(irqPriority),
        .ccPop(ccPop), .wakeRcClock(wakeRcClock), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .mainOscEn(mainOscEn),
        .rtcClkEn(rtcClkEn), .rcOscEn(rcOscEn),
        .timerCaptureInputOne(timerCaptureInputOne), .ccMask(ccMask),
        .maskLoad(maskLoad), .ccPush(ccPush), .serveIrq(serveIrq),
        .fetchResetVec(fetchResetVec), .watchdogReset(watchdogReset),
        .wakeIrq(wakeIrq));

    lpm_partner #(.RC_HALF_NS(RC_HALF_NS)) u_lpm_partner (.clock(clock),
        .resetn(resetn),
        .rcOscEn(rcOscEn), .serveIrq(serveIrq), .irqKick(irqKick),
        .anyIrq(anyIrq), .haltWakeIrq(haltWakeIrq), .rtcIrq(rtcIrq),
        .wakeRcClock(wakeRcClock));

    // Free-running 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] got,
                         input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Read data taken at the accept edge against the oldest note
    always @(posedge clock) begin
        if (read && waitrequest === 1'b0) begin
            check("readdata", readdata, {24'h0, expQ.pop_front()});
        end
    end

    // Hang guard; the whole run needs well under 5000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            conclude();
        end
    end

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge clock);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= {24'h0, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        expQ.push_back(exp);
        bus(1'b0, idx, 8'h00);
    endtask

    // Bits: ccPop, haltInstr, waitInstr, then the three interrupt kicks
    task automatic pulse(input logic [5:0] p);
        @(posedge clock);
        {ccPop, haltInstr, waitInstr, irqKick} <= p;
        @(posedge clock);
        {ccPop, haltInstr, waitInstr, irqKick} <= 6'h00;
    endtask

    // Bounded wait: 0 service, 1 reset vector, 2 watchdog reset
    task automatic waitEvt(input int sel, output int cnt);
        cnt = 0;
        do begin
            @(posedge clock);
            cnt++;
        end while (cnt < 5000 && (sel == 0 ? serveIrq : sel == 1 ?
            fetchResetVec : watchdogReset) !== 1'b1);
    endtask

    // Main sequence
    initial begin
        {resetn, read, write, waitInstr, haltInstr, ccPop} = 6'h00;
        {watchdogEnabled, watchdogInHaltOption, longStartOption} = 3'h0;
        address = 10'h000;
        writedata = 32'h0;
        irqPriority = 2'h0;
        irqKick = 3'h0;
        void'($urandom(32'hD8B4B490));
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        waitEvt(1, n);
        check("resetStart", n >= 257 && n <= 262, 1);
        check("cpuClkEn", cpuClkEn, 1'b1);
        rd(LPM_IDX_WAKE_CSR, 8'h00);
        rd(LPM_IDX_WAKE_PRE, 8'hFF);
        rd(LPM_IDX_MODE_CFG, 8'h00);
        rd(LPM_IDX_MODE_STAT, 8'h01);
        rd(8'h30, 8'h00);
        // Flag and upper bits ignore writes; measure routes the RC clock
        bus(1'b1, LPM_IDX_WAKE_CSR, 8'hFF);
        rd(LPM_IDX_WAKE_CSR, 8'h03);
        seen = 1'b0;
        repeat (30) @(posedge clock) seen |= timerCaptureInputOne;
        check("rcOscEn", rcOscEn, 1'b1);
        check("capture", seen, 1'b1);
        bus(1'b1, LPM_IDX_WAKE_CSR, 8'h00);
        repeat (8) @(posedge clock);
        check("captureOff", timerCaptureInputOne, 1'b0);
        // Prescaler refuses 00h, keeps any other value
        bus(1'b1, LPM_IDX_WAKE_PRE, 8'h00);
        rd(LPM_IDX_WAKE_PRE, 8'hFF);
        pre = 8'($urandom_range(1, 255));
        bus(1'b1, LPM_IDX_WAKE_PRE, pre);
        rd(LPM_IDX_WAKE_PRE, pre);
        // Wait: CPU stops, mask forced, interrupt vectors with priority
        // Odd priority only, so the pop back to 10 is visible
        irqPriority <= 2'($urandom) | 2'h1;
        pulse(6'h08);
        repeat (2) @(posedge clock);
        check("waitCpu", {cpuClkEn, periphClkEn}, 2'b01);
        check("waitMask", ccMask, 2'h2);
        rd(LPM_IDX_MODE_STAT, 8'h02);
        pulse(6'h01);
        waitEvt(0, n);
        check("waitExit", n <= 4, 1);
        check("push", {ccPush, ccMask}, {1'b1, irqPriority});
        check("pushLoad", maskLoad, 1'b1);
        pulse(6'h20);
        repeat (2) @(posedge clock);
        check("popMask", ccMask, 2'h2);
        // Halt with watchdog option clear requests a watchdog reset
        watchdogEnabled <= 1'b1;
        pulse(6'h10);
        waitEvt(2, n);
        check("wdReset", n <= 3, 1);
        rd(LPM_IDX_MODE_STAT, 8'h01);
        watchdogInHaltOption <= 1'b1;
        pulse(6'h10);
        repeat (3) @(posedge clock);
        check("haltClk", {mainOscEn, periphClkEn}, 2'b00);
        check("haltMask", ccMask, 2'h2);
        rd(LPM_IDX_MODE_STAT, 8'h04);
        pulse(6'h02);
        waitEvt(0, n);
        check("haltExit", n >= 257 && n <= 262, 1);
        // Active halt never resets through the watchdog
        watchdogInHaltOption <= 1'b0;
        bus(1'b1, LPM_IDX_MODE_CFG, 8'h01);
        pulse(6'h10);
        repeat (3) @(posedge clock);
        rd(LPM_IDX_MODE_STAT, 8'h08);
        check("actClk", {mainOscEn, rtcClkEn, periphClkEn}, 3'b110);
        pulse(6'h04);
        waitEvt(0, n);
        check("actExit", n <= 4, 1);
        // Reset out of active halt still passes the start-up delay
        pulse(6'h10);
        repeat (3) @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        waitEvt(1, n);
        check("actReset", n >= 257 && n <= 262, 1);
        // Auto wake with prescaler 01h: 64 RC periods plus start-up
        watchdogEnabled <= 1'b0;
        bus(1'b1, LPM_IDX_WAKE_PRE, 8'h01);
        bus(1'b1, LPM_IDX_WAKE_CSR, 8'h01);
        pulse(6'h10);
        repeat (3) @(posedge clock);
        check("awClk", {rcOscEn, mainOscEn}, 2'b10);
        waitEvt(0, n);
        check("awTime", n >= AW_LO && n <= AW_LO + 16, 1);
        check("wakeIrq", wakeIrq, 1'b1);
        rd(LPM_IDX_WAKE_CSR, 8'h05);
        rd(LPM_IDX_WAKE_CSR, 8'h01);
        check("wakeClr", wakeIrq, 1'b0);
        conclude();
    end
endmodule
